// [core/kpw_pkg.sv]
// Operation
// - up to eight event inputs, each with its own enable; disabled inputs never count.
// - each input senses edge only or edge plus level, falling/low or rising/high.
// - all enabled inputs share one pending flag and one maskable request line.
// - enabling inputs may set the flag falsely; software clears it before enabling request.
// - the block keeps running in wait mode and its request wakes the processor.
// - in partial stop, enabled active inputs wake the processor without the bus clock while the request enable is one.
// - in both power-off stop states the block is disabled and returns to reset.
// - in background debug halt the block behaves exactly as in run mode.
// - three 8-bit registers: status and control, input enables, polarity selects.
// - an edge is inactive level in one cycle then active level in the next.
// - after an edge, no new edge until every enabled input is inactive again.
// - writing one to the clear strobe clears the flag unless a new edge or, in level mode, an active level sets it again.
// - the request is asserted while the flag is set and the request enable is one.
package kpw_pkg;

    localparam int MAX_PINS = 8;
    localparam int REG_W    = 8;
    localparam int APB_AW   = 12;
    localparam int APB_DW   = 32;

    localparam logic [APB_AW-1:0] CTRL_OFFSET       = 12'h000;
    localparam logic [APB_AW-1:0] ENABLE_OFFSET     = 12'h004;
    localparam logic [APB_AW-1:0] POLARITY_OFFSET   = 12'h008;
    localparam logic [APB_AW-1:0] EVT_STATUS_OFFSET = 12'h00C;
    localparam logic [APB_AW-1:0] EVT_MASK_OFFSET   = 12'h010;

    // status and control layout
    localparam int MODE_BIT  = 0;
    localparam int IRQEN_BIT = 1;
    localparam int CLEAR_BIT = 2;
    localparam int FLAG_BIT  = 3;

    // sticky event status layout, shared by the mask register
    localparam int EVT_W         = 3;
    localparam int EVT_FLAG_BIT  = 0;
    localparam int EVT_WAKE_BIT  = 1;
    localparam int EVT_HELD_BIT  = 2;

    localparam logic [REG_W-1:0] ENABLE_RESET   = 8'h00;
    localparam logic [REG_W-1:0] POLARITY_RESET = 8'h00;
    localparam logic [EVT_W-1:0] EVT_RESET      = 3'h0;
    localparam logic [EVT_W-1:0] MASK_RESET     = 3'h0;

    typedef struct packed {
        logic irq_enable;
        logic level_mode;
    } kpw_cfg_type;

    localparam kpw_cfg_type CFG_RESET = '{irq_enable: 1'h0, level_mode: 1'h0};

    typedef struct packed {
        logic held;
        logic wake;
        logic flag_set;
    } kpw_evt_type;

endpackage

// [core/kpw_sync.sv]
`timescale 1ns/1ps
module kpw_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic             clr,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    always_comb begin
        meta_next = clr ? '0 : d;
        q_next    = clr ? '0 : meta_reg;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q = q_reg;
endmodule // kpw_sync

// [core/kpw_pin_sense.sv]
`timescale 1ns/1ps
module kpw_pin_sense (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic clr,
    input  wire logic pin_sync,
    input  wire logic enable,
    input  wire logic polarity,
    output logic      active,
    output logic      edge_seen
);
    logic level_raw;
    logic prev_reg;
    logic prev_next;

    // polarity 1 means rising edge / high level
    assign level_raw = polarity ? pin_sync : ~pin_sync;

    always_comb begin
        prev_next = clr ? 1'h0 : level_raw;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prev_reg <= 1'h0;
        end else begin
            prev_reg <= prev_next;
        end
    end

    assign active    = enable & level_raw;
    // inactive last cycle, active now
    assign edge_seen = active & ~prev_reg;
endmodule // kpw_pin_sense

// [core/kpw_top.sv]
`timescale 1ns/1ps
module kpw_top #(
    parameter int NUM_PINS = kpw_pkg::MAX_PINS
) (
    input  wire logic                       mclk,
    input  wire logic                       rstn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [kpw_pkg::APB_AW-1:0] paddr,
    input  wire logic [kpw_pkg::APB_DW-1:0] pwdata,
    output logic      [kpw_pkg::APB_DW-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [NUM_PINS-1:0]        event_input_pins,
    input  wire logic                       wait_mode,
    input  wire logic                       partial_stop_state,
    input  wire logic                       power_off_stop_a,
    input  wire logic                       power_off_stop_b,
    input  wire logic                       debug_halt,
    output logic                            event_irq_request,
    output logic                            wake_request,
    output logic                            irq
);

    if (NUM_PINS < 1 || NUM_PINS > kpw_pkg::MAX_PINS) begin : g_bad_pins
        $error("kpw_top: NUM_PINS must lie between 1 and 8");
    end

    // ---------------------------------------------------------------
    // power state
    // ---------------------------------------------------------------
    logic                       off_clr;
    // both power-off stops hold every register at its reset value, so leaving
    // them always finds the block freshly reset
    assign off_clr = power_off_stop_a | power_off_stop_b;

    // debug halt needs no gating: detection, flag and request carry on
    logic                       debug_unused;
    assign debug_unused = debug_halt;

    // ---------------------------------------------------------------
    // software state
    // ---------------------------------------------------------------
    kpw_pkg::kpw_cfg_type       cfg_reg;
    kpw_pkg::kpw_cfg_type       cfg_next;
    logic [NUM_PINS-1:0]        enable_reg;
    logic [NUM_PINS-1:0]        enable_next;
    logic [NUM_PINS-1:0]        polarity_reg;
    logic [NUM_PINS-1:0]        polarity_next;
    logic [kpw_pkg::EVT_W-1:0]  evt_status_reg;
    logic [kpw_pkg::EVT_W-1:0]  evt_status_next;
    logic [kpw_pkg::EVT_W-1:0]  evt_mask_reg;
    logic [kpw_pkg::EVT_W-1:0]  evt_mask_next;
    logic [kpw_pkg::APB_DW-1:0] prdata_reg;
    logic [kpw_pkg::APB_DW-1:0] prdata_next;

    // ---------------------------------------------------------------
    // detection state
    // ---------------------------------------------------------------
    logic                       flag_reg;
    logic                       flag_next;
    logic                       armed_reg;
    logic                       armed_next;
    logic                       wake_prev_reg;
    logic                       wake_prev_next;

    logic [NUM_PINS-1:0]        pins_sync;
    logic [NUM_PINS-1:0]        pin_active;
    logic [NUM_PINS-1:0]        pin_edge;
    logic                       any_active;
    logic                       any_edge;
    logic                       edge_hit;
    logic                       level_hit;
    logic                       set_hit;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic                       setup_phase;
    logic                       access_phase;
    logic                       wr_access;
    logic                       rd_access;
    logic                       addr_ok;
    logic                       clear_write;
    logic                       status_read;
    logic [kpw_pkg::REG_W-1:0]  wbyte;

    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign wr_access    = access_phase & pwrite;
    assign rd_access    = access_phase & ~pwrite;
    assign wbyte        = pwdata[kpw_pkg::REG_W-1:0];

    always_comb begin
        unique case (paddr)
            kpw_pkg::CTRL_OFFSET,
            kpw_pkg::ENABLE_OFFSET,
            kpw_pkg::POLARITY_OFFSET,
            kpw_pkg::EVT_STATUS_OFFSET,
            kpw_pkg::EVT_MASK_OFFSET: begin
                addr_ok = 1'h1;
            end
            default: begin
                addr_ok = 1'h0;
            end
        endcase
    end

    // zero wait states; unmapped addresses answer with an error and no effect
    assign pready  = 1'h1;
    assign pslverr = access_phase & ~addr_ok;

    assign clear_write = wr_access & (paddr == kpw_pkg::CTRL_OFFSET)
                         & wbyte[kpw_pkg::CLEAR_BIT];
    assign status_read = rd_access & (paddr == kpw_pkg::EVT_STATUS_OFFSET);

    // ---------------------------------------------------------------
    // input path
    // ---------------------------------------------------------------
    kpw_sync #(
        .WIDTH (NUM_PINS)
    ) u_sync (
        .mclk  (mclk),
        .rstn  (rstn),
        .clr   (off_clr),
        .d     (event_input_pins),
        .q     (pins_sync)
    );

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        kpw_pin_sense u_sense (
            .mclk      (mclk),
            .rstn      (rstn),
            .clr       (off_clr),
            .pin_sync  (pins_sync[i]),
            .enable    (enable_reg[i]),
            .polarity  (polarity_reg[i]),
            .active    (pin_active[i]),
            .edge_seen (pin_edge[i])
        );
    end

    assign any_active = |pin_active;
    assign any_edge   = |pin_edge;

    // an edge only counts once every enabled input has been seen inactive;
    // the lock starts closed at reset; inputs already asserted at enable give no edge since prev_reg follows them while disabled
    assign edge_hit  = armed_reg & any_edge;
    // level mode keeps setting the flag while any enabled input stays asserted
    assign level_hit = cfg_reg.level_mode & any_active;
    assign set_hit   = edge_hit | level_hit;

    always_comb begin
        armed_next = armed_reg;
        if (off_clr) begin
            armed_next = 1'h0;
        end else if (!any_active) begin
            armed_next = 1'h1;
        end else if (any_edge) begin
            armed_next = 1'h0;
        end
    end

    always_comb begin
        flag_next = flag_reg;
        if (off_clr) begin
            flag_next = 1'h0;
        end else if (set_hit) begin
            // a new event or a still-asserted level beats the clear strobe
            flag_next = 1'h1;
        end else if (clear_write) begin
            flag_next = 1'h0;
        end
    end

    // enabling pins can raise the flag at once; software clears it before
    // setting the request enable, nothing here hides that false flag
    assign event_irq_request = flag_reg & cfg_reg.irq_enable;

    // ---------------------------------------------------------------
    // wake-up
    // ---------------------------------------------------------------
    logic                       stop_hit;
    logic [NUM_PINS-1:0]        raw_level;

    // in partial stop the bus clock may stand still, so the wake path looks at
    // the raw pins through gates only; a pulse shorter than the restart time
    // wakes the part but may not reach the flag
    assign raw_level = ~(event_input_pins ^ polarity_reg) & enable_reg;
    assign stop_hit  = partial_stop_state & cfg_reg.irq_enable & (|raw_level);

    // wait mode keeps the clock, so the normal request wakes the processor
    assign wake_request = (wait_mode & event_irq_request) | stop_hit;

    always_comb begin
        wake_prev_next = off_clr ? 1'h0 : wake_request;
    end

    // ---------------------------------------------------------------
    // software registers
    // ---------------------------------------------------------------
    kpw_pkg::kpw_evt_type       evt_now;

    assign evt_now.flag_set = set_hit & ~flag_reg;
    assign evt_now.wake     = wake_request & ~wake_prev_reg;
    assign evt_now.held     = clear_write & set_hit;

    always_comb begin
        cfg_next      = cfg_reg;
        enable_next   = enable_reg;
        polarity_next = polarity_reg;
        evt_mask_next = evt_mask_reg;
        if (off_clr) begin
            cfg_next      = kpw_pkg::CFG_RESET;
            enable_next   = kpw_pkg::ENABLE_RESET[NUM_PINS-1:0];
            polarity_next = kpw_pkg::POLARITY_RESET[NUM_PINS-1:0];
            evt_mask_next = kpw_pkg::MASK_RESET;
        end else if (wr_access) begin
            unique case (paddr)
                kpw_pkg::CTRL_OFFSET: begin
                    cfg_next.level_mode = wbyte[kpw_pkg::MODE_BIT];
                    cfg_next.irq_enable = wbyte[kpw_pkg::IRQEN_BIT];
                end
                kpw_pkg::ENABLE_OFFSET: begin
                    enable_next = wbyte[NUM_PINS-1:0];
                end
                kpw_pkg::POLARITY_OFFSET: begin
                    polarity_next = wbyte[NUM_PINS-1:0];
                end
                kpw_pkg::EVT_MASK_OFFSET: begin
                    evt_mask_next = wbyte[kpw_pkg::EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        evt_status_next = evt_status_reg;
        if (off_clr) begin
            evt_status_next = kpw_pkg::EVT_RESET;
        end else begin
            if (status_read) begin
                // clear only what this read reported; a bit latched at its setup edge stays
                evt_status_next = evt_status_reg & ~prdata_reg[kpw_pkg::EVT_W-1:0];
            end
            // a new event in the read cycle survives the read-clear
            evt_status_next = evt_status_next | evt_now;
        end
    end

    assign irq = |(evt_status_reg & evt_mask_reg);

    // read data is captured in the setup phase and shown in the access phase
    always_comb begin
        prdata_next = '0;
        if (setup_phase && !pwrite) begin
            unique case (paddr)
                kpw_pkg::CTRL_OFFSET: begin
                    prdata_next[kpw_pkg::MODE_BIT]  = cfg_reg.level_mode;
                    prdata_next[kpw_pkg::IRQEN_BIT] = cfg_reg.irq_enable;
                    prdata_next[kpw_pkg::FLAG_BIT]  = flag_reg;
                end
                kpw_pkg::ENABLE_OFFSET: begin
                    prdata_next[NUM_PINS-1:0] = enable_reg;
                end
                kpw_pkg::POLARITY_OFFSET: begin
                    prdata_next[NUM_PINS-1:0] = polarity_reg;
                end
                kpw_pkg::EVT_STATUS_OFFSET: begin
                    prdata_next[kpw_pkg::EVT_W-1:0] = evt_status_reg;
                end
                kpw_pkg::EVT_MASK_OFFSET: begin
                    prdata_next[kpw_pkg::EVT_W-1:0] = evt_mask_reg;
                end
                default: begin
                end
            endcase
        end else if (access_phase) begin
            prdata_next = prdata_reg;
        end
    end

    assign prdata = prdata_reg;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfg_reg        <= kpw_pkg::CFG_RESET;
            enable_reg     <= kpw_pkg::ENABLE_RESET[NUM_PINS-1:0];
            polarity_reg   <= kpw_pkg::POLARITY_RESET[NUM_PINS-1:0];
            evt_status_reg <= kpw_pkg::EVT_RESET;
            evt_mask_reg   <= kpw_pkg::MASK_RESET;
            prdata_reg     <= '0;
            flag_reg       <= 1'h0;
            armed_reg      <= 1'h0;
            wake_prev_reg  <= 1'h0;
        end else begin
            cfg_reg        <= cfg_next;
            enable_reg     <= enable_next;
            polarity_reg   <= polarity_next;
            evt_status_reg <= evt_status_next;
            evt_mask_reg   <= evt_mask_next;
            prdata_reg     <= prdata_next;
            flag_reg       <= flag_next;
            armed_reg      <= armed_next;
            wake_prev_reg  <= wake_prev_next;
        end
    end

endmodule // kpw_top

// [bench/kpw_keypad_model.sv]
`timescale 1ns/1ps
module kpw_keypad_model (
    input  wire logic       mclk,
    input  wire logic       slow,
    input  wire logic [7:0] press,
    input  wire logic [7:0] rise_pol,
    output logic      [7:0] pins
);
    logic [7:0] lag = 8'hF0;
    // a held key shows its active level, a free key rests at its idle level
    always @(posedge mclk) begin
        lag  <= ~(press ^ rise_pol);
        pins <= slow ? lag : ~(press ^ rise_pol);
    end
endmodule // kpw_keypad_model

// [bench/kpw_top_properties.sv]
`timescale 1ns/1ps
module kpw_top_properties #(
    parameter int NUM_PINS = kpw_pkg::MAX_PINS
) (
    input wire logic                       mclk,
    input wire logic                       rstn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [kpw_pkg::APB_AW-1:0] paddr,
    input wire logic [kpw_pkg::APB_DW-1:0] pwdata,
    input wire logic                       pslverr,
    input wire logic [NUM_PINS-1:0]        event_input_pins,
    input wire logic                       wait_mode,
    input wire logic                       partial_stop_state,
    input wire logic                       power_off_stop_a,
    input wire logic                       power_off_stop_b,
    input wire logic                       event_irq_request,
    input wire logic                       wake_request,
    input wire logic                       irq
);
    logic [3:0]          quiet_reg, quiet_next;
    logic                mode_reg, mode_next;
    logic [NUM_PINS-1:0] pins_reg;
    logic                acc, ctrl_wr, off, drop_cause;
    assign acc        = psel & penable;
    assign ctrl_wr    = acc & pwrite & (paddr == kpw_pkg::CTRL_OFFSET);
    assign off        = power_off_stop_a | power_off_stop_b;
    assign drop_cause = ctrl_wr | off;
    // shadow of the mode bit; cycles since the last pin change or bus access
    always_comb begin
        mode_next  = off ? 1'h0 : (ctrl_wr ? pwdata[kpw_pkg::MODE_BIT] : mode_reg);
        quiet_next = (quiet_reg == 4'hF) ? quiet_reg : quiet_reg + 4'h1;
        if (psel || event_input_pins != pins_reg)
            quiet_next = 4'h0;
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            quiet_reg <= 4'h0;
            mode_reg  <= 1'h0;
            pins_reg  <= '0;
        end else begin
            quiet_reg <= quiet_next;
            mode_reg  <= mode_next;
            pins_reg  <= event_input_pins;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    chk_unmapped_error: assert property (acc && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > kpw_pkg::EVT_MASK_OFFSET)) else $error("pslverr wrong");
    chk_irqen_off: assert property (ctrl_wr && !pwdata[1] |=> !event_irq_request)
        else $error("request while disabled");
    chk_clear_quiet: assert property ($stable(event_input_pins)[*4] ##0
        (ctrl_wr && pwdata[2] && !pwdata[0] && !mode_reg) |=> !event_irq_request)
        else $error("clear ignored");
    chk_wait_wake: assert property (wait_mode && event_irq_request |-> wake_request)
        else $error("no wake in wait");
    chk_wake_idle: assert property (!wait_mode && !partial_stop_state |-> !wake_request)
        else $error("wake in run");
    chk_power_off: assert property (off |=> !event_irq_request && !irq)
        else $error("not cleared by power-off");
    chk_flag_cause: assert property ($rose(event_irq_request) |-> quiet_reg <= 4'h6)
        else $error("request without cause");
    chk_request_holds: assert property ($fell(event_irq_request) |-> $past(drop_cause))
        else $error("request dropped");
    cover property (wait_mode && wake_request);
    cover property (partial_stop_state && wake_request);
    cover property ($rose(irq));
endmodule // kpw_top_properties

bind kpw_top kpw_top_properties #(.NUM_PINS(NUM_PINS)) u_props (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .event_input_pins(event_input_pins),
    .wait_mode(wait_mode), .partial_stop_state(partial_stop_state),
    .power_off_stop_a(power_off_stop_a), .power_off_stop_b(power_off_stop_b),
    .event_irq_request(event_irq_request), .wake_request(wake_request), .irq(irq)
);

// [bench/test_key_pin_wakeup_irq.sv]
`timescale 1ns/1ps
module test_key_pin_wakeup_irq;
    localparam logic [11:0] A_CTL = kpw_pkg::CTRL_OFFSET;
    localparam logic [11:0] A_EN  = kpw_pkg::ENABLE_OFFSET;
    localparam logic [11:0] A_POL = kpw_pkg::POLARITY_OFFSET;
    localparam logic [11:0] A_ST  = kpw_pkg::EVT_STATUS_OFFSET;
    localparam logic [11:0] A_MSK = kpw_pkg::EVT_MASK_OFFSET;
    localparam logic [7:0]  POL   = 8'h0F;
    logic        mclk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, last_err = 1'h0, req, wake, irq;
    logic [7:0]  pins, press = 8'h00;
    logic        slow = 1'h0, wait_mode = 1'h0, part_stop = 1'h0;
    logic        off_a = 1'h0, off_b = 1'h0, dbg = 1'h0;
    int          err_total = 0, checked = 0;

    always #12.5 mclk = ~mclk;

    kpw_top uut (
        .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_input_pins(pins), .wait_mode(wait_mode),
        .partial_stop_state(part_stop), .power_off_stop_a(off_a),
        .power_off_stop_b(off_b), .debug_halt(dbg), .event_irq_request(req),
        .wake_request(wake), .irq(irq)
    );
    kpw_keypad_model u_keys (
        .mclk(mclk), .slow(slow), .press(press), .rise_pol(POL), .pins(pins)
    );

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s: got %h, expected %h", $time, what, got, exp);
        end
    endtask

    // one transfer, then one idle cycle so no strobe is driven twice in a time step
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
                        output logic [31:0] q);
        int n;
        psel   <= 1'h1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (n >= 16) begin
            err_total++;
            wrap_up();
        end
        q = prdata;
        last_err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'h1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input string what);
        logic [31:0] q;
        xfer(1'h0, a, 8'h00, q);
        chk(q, {24'h0, e}, what);
    endtask

    task automatic await_req(input logic e, input string what);
        for (int n = 0; n < 12 && req !== e; n++)
            @(posedge mclk);
        chk(32'(req), 32'(e), what);
    endtask

    task automatic keys_up();
        press <= 8'h00;
        repeat (6) @(posedge mclk);
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        rstn <= 1'h1;
        @(posedge mclk);
        for (int i = 0; i < 5; i++)
            rd(12'(4 * i), 8'h00, "reset value");
        wr(A_POL, POL);
        wr(A_EN, 8'hFF);
        wr(A_CTL, 8'h04);
        @(posedge mclk);
        wr(A_CTL, 8'h02);
        wr(A_MSK, 8'h07);
        rd(A_ST, 8'h00, "false event");
        $display("test done: reset and init");
        for (int i = 0; i < 8; i++) begin
            dbg   <= (i > 3);
            slow  <= i[0];
            press <= 8'h01 << i;
            await_req(1'h1, "edge request");
            chk(32'(irq), 32'h1, "irq");
            rd(A_CTL, 8'h0A, "flag visible");
            rd(A_ST, 8'h01, "flag event");
            keys_up();
            wr(A_CTL, 8'h06);
            await_req(1'h0, "clear");
        end
        dbg   <= 1'h0;
        slow  <= 1'h0;
        press <= 8'h01;
        $display("test done: every pin");
        await_req(1'h1, "first edge");
        wr(A_CTL, 8'h06);
        press <= 8'h03;
        repeat (8) @(posedge mclk);
        chk(32'(req), 32'h0, "edge while held");
        keys_up();
        wr(A_MSK, 8'h00);
        chk(32'(irq), 32'h0, "masked irq");
        wr(A_MSK, 8'h07);
        rd(A_ST, 8'h01, "sticky status");
        chk(32'(irq), 32'h0, "irq after read");
        wr(A_EN, 8'hFB);
        press <= 8'h04;
        repeat (8) @(posedge mclk);
        chk(32'(req), 32'h0, "disabled pin");
        keys_up();
        wr(A_EN, 8'hFF);
        $display("test done: lockout and enables");
        wr(A_CTL, 8'h03);
        press <= 8'h20;
        await_req(1'h1, "level flag");
        wr(A_CTL, 8'h07);
        rd(A_CTL, 8'h0B, "refused clear");
        rd(A_ST, 8'h05, "refused event");
        keys_up();
        wr(A_CTL, 8'h07);
        rd(A_CTL, 8'h03, "clear after release");
        wr(A_CTL, 8'h02);
        press <= 8'h02;
        repeat (3) @(posedge mclk);
        rd(A_ST, 8'h00, "event at read setup");
        rd(A_ST, 8'h01, "event kept by read-clear");
        keys_up();
        wr(A_CTL, 8'h06);
        $display("test done: level mode");
        wait_mode <= 1'h1;
        press <= 8'h80;
        await_req(1'h1, "request in wait");
        chk(32'(wake), 32'h1, "wake in wait");
        rd(A_ST, 8'h03, "wake event");
        keys_up();
        wr(A_CTL, 8'h06);
        wait_mode <= 1'h0;
        part_stop <= 1'h1;
        press <= 8'h40;
        repeat (2) @(posedge mclk);
        chk(32'(wake), 32'h1, "wake in stop");
        press <= 8'h00;
        repeat (3) @(posedge mclk);
        chk(32'(wake), 32'h0, "wake ends");
        part_stop <= 1'h0;
        repeat (4) @(posedge mclk);
        wr(A_CTL, 8'h06);
        rd(A_ST, 8'h03, "stop events");
        $display("test done: low power wake");
        for (int i = 0; i < 2; i++) begin
            wr(A_EN, 8'h5A);
            wr(A_CTL, 8'h03);
            off_a <= (i == 0);
            off_b <= (i == 1);
            @(posedge mclk);
            off_a <= 1'h0;
            off_b <= 1'h0;
            @(posedge mclk);
            for (int j = 0; j < 5; j++)
                rd(12'(4 * j), 8'h00, "power-off value");
        end
        wr(12'h014, 8'hFF);
        chk(32'(last_err), 32'h1, "unmapped write");
        rd(12'h014, 8'h00, "unmapped read");
        $display("test done: power-off and unmapped");
        wrap_up();
    end
endmodule // test_key_pin_wakeup_irq
